// >>> include/edb_defines.vh
// Constants for the external data bus command and configuration block.
// Assumes byte offsets on the host register port and a 10 MHz ref_clk.
`ifndef EDB_DEFINES_VH
`define EDB_DEFINES_VH

// Register byte offsets
`define EDB_OFS_CONFIG      8'h7C
`define EDB_OFS_COMMAND     8'h80
`define EDB_OFS_PAGE        8'h84
`define EDB_OFS_ADDR_DATA   8'h88

// Writable bit masks, reserved bits stay zero
`define EDB_CONFIG_MASK     32'hD3FF_0000
`define EDB_PAGE_MASK       32'hFFFF_F800

// Reset values
`define EDB_CONFIG_RST      32'h0000_0000
`define EDB_COMMAND_RST     32'h0000_0000
`define EDB_PAGE_RST        32'h0000_0000
`define EDB_ADDR_DATA_RST   32'h0000_0000

// Configuration fields
`define EDB_CFG_HALT_EN     31
`define EDB_CFG_RESUME      30
`define EDB_CFG_FAST        28
`define EDB_CFG_TMO_HI      25
`define EDB_CFG_TMO_LO      22
`define EDB_CFG_SWAP_HI     21
`define EDB_CFG_SWAP_LO     20
`define EDB_CFG_WORD        19
`define EDB_CFG_INCR        18
`define EDB_CFG_RDY_MODE    17
`define EDB_CFG_TIMER_N     16

// Command fields
`define EDB_CMD_LEN_HI      31
`define EDB_CMD_LEN_LO      17
`define EDB_CMD_DIR         16
`define EDB_CMD_ADDR_HI     15

// Paging fields
`define EDB_PAGE_BASE_HI    31
`define EDB_PAGE_BASE_LO    12
`define EDB_PAGE_EN         11

// Transfer length limits
`define EDB_IMM_MAX         15'h0004

// Endian swap codes
`define EDB_SWAP_TWO        2'h1
`define EDB_SWAP_FOUR       2'h2

// Idle cycles between strobes
`define EDB_GAP_FAST        3'h1
`define EDB_GAP_SLOW        3'h2
`define EDB_GAP_INC_WR      3'h3
`define EDB_GAP_INC_RD      3'h4

// Synchroniser reset: gp pin, acknowledge and ready idle high
`define EDB_SYNC_W          19
`define EDB_SYNC_RST        19'h7_0000

`endif

// >>> hw/edb_sync3.v
// Three-stage input synchroniser for pins of the external data bus.
// Assumes inputs are asynchronous to ref_clk; output moves once the
// second and third stages agree.
`timescale 1ns/100ps
module edb_sync3 #(
  parameter          W   = 19,
  parameter [W-1:0]  RST = {W{1'b0}}
) (
  input  wire         ref_clk,
  input  wire         resetn,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg q_reg;
      // Three stage flops plus an output flop that follows agreeing later stages
      always @(posedge ref_clk) begin
        if (!resetn) begin
          s1_reg <= RST[i];
          s2_reg <= RST[i];
          s3_reg <= RST[i];
          q_reg  <= RST[i];
        end else begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign dout[i] = q_reg;
    end
  endgenerate

endmodule

// >>> hw/edb_cmd_regs.v
// Command, configuration and transfer sequencer of the external data bus.
// Assumes a host register port on ref_clk, a DMA engine answering dmaReq
// with a one-cycle dmaAck, and external pad logic resolving adOe.
`timescale 1ns/100ps
`include "edb_defines.vh"

// Overview of operation
// RULE1 - Three command words; command write starts transfer
// RULE2 - Config bit 31: gp pin low halts
// RULE3 - Config bit 30: resume after halt release
// RULE4 - Config bit 28: fast mode, short idle
// RULE5 - Config bits 25:22 load cycle timer
// RULE6 - Swap field: none, two-byte, four-byte
// RULE7 - Config bit 19: target serves 16-bit cycles
// RULE8 - Config bit 18: address phase per data
// RULE9 - Config bit 17: ready or acknowledge handshake
// RULE10 - Config bit 16 low enables timer
// RULE11 - Length above four is block, else immediate
// RULE12 - Command bit 16 high reads target
// RULE13 - Command bits 15:0 give target address
// RULE14 - Paging word: base and enable bit
// RULE15 - Address/data word: data or DMA address
// RULE16 - Software keeps DMA address Dword aligned
// RULE17 - Timer expiry sets overflow flag
// RULE18 - Immediate Dword crossing refused, format error
// RULE19 - Halt without resume terminates block
// RULE20 - Strobe width is timer plus one
// RULE21 - Reserved bits ignore writes, read zero
module edb_cmd_regs (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  output wire [31:0] regRdata,
  input  wire        timerOverflowClr,
  input  wire        formatErrorClr,
  output wire        timerOverflowFlag,
  output wire        formatErrorFlag,
  output wire        transferActive,
  output wire        dmaReq,
  output wire        dmaRead,
  output wire [31:0] dmaAddr,
  output wire [31:0] dmaWdata,
  input  wire        dmaAck,
  input  wire [31:0] dmaRdata,
  output wire        dmaPagingEnable,
  output wire [19:0] dmaPageBase,
  input  wire [15:0] adIn,
  output wire [15:0] adOut,
  output wire        adOe,
  output wire        aleOut,
  output wire        wrStrobeN,
  output wire        rdStrobeN,
  output wire        dataStrobeN,
  output wire        readNotWrite,
  output wire        wideCycle,
  input  wire        readyIn,
  input  wire        dtackN,
  input  wire        gpPinThree
);

  localparam ST_IDLE   = 4'h0;
  localparam ST_FETCH  = 4'h1;
  localparam ST_ADDR1  = 4'h2;
  localparam ST_ADDR2  = 4'h3;
  localparam ST_STROBE = 4'h4;
  localparam ST_GAP    = 4'h5;
  localparam ST_STORE  = 4'h6;
  localparam ST_HALT   = 4'h7;

  reg [31:0] cfg_reg;
  reg [31:0] cfgAct_reg;
  reg [31:0] cmd_reg;
  reg [31:0] page_reg;
  reg [31:0] ad_reg;
  reg [31:0] rdData_reg;
  reg [31:0] buf_reg;
  reg [31:0] dmaWdata_reg;
  reg [15:0] adOut_reg;
  reg        adOe_reg;
  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [3:0]  cnt_reg;
  reg [2:0]  gap_reg;
  reg [1:0]  lane_reg;
  reg        wrap_reg;
  reg        block_reg;
  reg        needAddr_reg;
  reg        upload_reg;
  reg        tmoFlag_reg;
  reg        fmtFlag_reg;

  wire [18:0] syncOut;
  wire [15:0] adSync    = syncOut[15:0];
  wire        rdySync   = syncOut[16];
  wire        dtackSync = syncOut[17];
  wire        gpSync    = syncOut[18];

  // Address match for register port
  function regHit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      regHit = (addr == ofs);
    end
  endfunction

  // Endian swap of one Dword
  function [31:0] swapWord;
    input [31:0] d;
    input [1:0]  m;
    begin
      case (m)
        `EDB_SWAP_TWO:  swapWord = {d[23:16], d[31:24], d[7:0], d[15:8]};
        `EDB_SWAP_FOUR: swapWord = {d[7:0], d[15:8], d[23:16], d[31:24]};
        default:        swapWord = d;
      endcase
    end
  endfunction

  // Select one byte lane of a Dword
  function [7:0] pickByte;
    input [31:0] w;
    input [1:0]  l;
    begin
      pickByte = w[{l, 3'b000} +: 8];
    end
  endfunction

  // Pin synchronisers for data, handshakes and gp pin
  edb_sync3 #(
    .W   (`EDB_SYNC_W),
    .RST (`EDB_SYNC_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({gpPinThree, dtackN, readyIn, adIn}),
    .dout    (syncOut)
  );

  // Command fields
  wire [14:0] lenField = cmd_reg[`EDB_CMD_LEN_HI:`EDB_CMD_LEN_LO]; // [RULE11]
  wire        dirRead  = cmd_reg[`EDB_CMD_DIR];            // [RULE12]
  wire [15:0] tgtAddr  = cmd_reg[`EDB_CMD_ADDR_HI:0];      // [RULE13]

  // Active configuration fields
  wire        haltEn    = cfgAct_reg[`EDB_CFG_HALT_EN];
  wire        resumeEn  = cfgAct_reg[`EDB_CFG_RESUME];
  wire        fastMode  = cfgAct_reg[`EDB_CFG_FAST];
  wire [3:0]  tmoSet    = cfgAct_reg[`EDB_CFG_TMO_HI:`EDB_CFG_TMO_LO];
  wire [1:0]  swapMode  = cfgAct_reg[`EDB_CFG_SWAP_HI:`EDB_CFG_SWAP_LO];
  wire        wordCap   = cfgAct_reg[`EDB_CFG_WORD];
  wire        incrMode  = cfgAct_reg[`EDB_CFG_INCR];
  wire        readyMode = cfgAct_reg[`EDB_CFG_RDY_MODE];
  wire        timerOn   = ~cfgAct_reg[`EDB_CFG_TIMER_N];   // [RULE10]

  // Start checks at upload
  wire isImm   = (lenField != 15'h0000) && (lenField <= `EDB_IMM_MAX);
  wire isBlock = (lenField > `EDB_IMM_MAX);
  wire crossDw = isImm &&
                 (({13'h0000, tgtAddr[1:0]} + lenField) > `EDB_IMM_MAX);
  wire startOk = (lenField != 15'h0000) && !crossDw;   // [RULE18]
  wire idleNow = (state_reg == ST_IDLE) && !upload_reg;

  // Unit size: 16-bit only on even address, even lane, two bytes left
  wire unitWide = wordCap && !lane_reg[0] && !tgtAddr[0] &&
                  (lenField > 15'h0001);                   // [RULE7]
  wire [1:0]  unitSize = unitWide ? 2'h2 : 2'h1;
  wire [2:0]  laneNext = {1'b0, lane_reg} + {1'b0, unitSize};
  wire [1:0]  hiLane   = lane_reg + 2'h1;

  // Strobe completion and timer expiry
  wire tmoHit     = timerOn && (cnt_reg == tmoSet);        // [RULE5]
  wire tmoReached = !timerOn || (cnt_reg >= tmoSet);
  wire strobeDone = readyMode ? (tmoReached && rdySync)   // [RULE9]
                              : (!dtackSync || tmoHit);   // [RULE20]
  wire inStrobe   = (state_reg == ST_STROBE);
  wire tmoEvent   = inStrobe && tmoHit &&
                    (readyMode ? !rdySync : dtackSync);    // [RULE17]

  // External halt request during block transfer
  wire haltReq = haltEn && !gpSync && block_reg;           // [RULE2]

  // Idle time between strobes
  wire [2:0] gapLen = incrMode ? (dirRead ? `EDB_GAP_INC_RD
                                          : `EDB_GAP_INC_WR)
                               : (fastMode ? `EDB_GAP_FAST
                                           : `EDB_GAP_SLOW); // [RULE4]

  // Write data for the next strobe, taken from fetch if just arriving
  wire [31:0] wrSrc  = (state_reg == ST_FETCH) ?
                       swapWord(dmaRdata, swapMode) : buf_reg; // [RULE6]
  wire [15:0] wrData = {unitWide ? pickByte(wrSrc, hiLane) : 8'h00,
                        pickByte(wrSrc, lane_reg)};

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (upload_reg && startOk) begin                   // [RULE1]
          state_next = (isBlock && !dirRead) ? ST_FETCH : ST_ADDR1;
        end
      end
      ST_FETCH: begin
        if (dmaAck) begin
          state_next = (needAddr_reg || incrMode) ? ST_ADDR1 : ST_STROBE;
        end
      end
      ST_ADDR1: begin
        state_next = ST_ADDR2;
      end
      ST_ADDR2: begin
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        if (strobeDone) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_reg == 3'h1) begin
          if (lenField == 15'h0000) begin
            state_next = (dirRead && block_reg) ? ST_STORE : ST_IDLE;
          end else if (wrap_reg) begin
            state_next = dirRead ? ST_STORE : ST_FETCH;
          end else if (haltReq) begin
            state_next = resumeEn ? ST_HALT : ST_IDLE;  // [RULE3] [RULE19]
          end else begin
            state_next = incrMode ? ST_ADDR1 : ST_STROBE;  // [RULE8]
          end
        end
      end
      ST_STORE: begin
        if (dmaAck) begin
          if (lenField == 15'h0000) begin
            state_next = ST_IDLE;
          end else begin
            state_next = incrMode ? ST_ADDR1 : ST_STROBE;
          end
        end
      end
      ST_HALT: begin
        if (!haltReq) begin
          state_next = ST_ADDR1;                           // [RULE3]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Host register writes and engine updates of live registers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_reg    <= `EDB_CONFIG_RST;
      cmd_reg    <= `EDB_COMMAND_RST;
      page_reg   <= `EDB_PAGE_RST;
      ad_reg     <= `EDB_ADDR_DATA_RST;
      cfgAct_reg <= `EDB_CONFIG_RST;
      upload_reg <= 1'b0;
      block_reg  <= 1'b0;
    end else begin
      upload_reg <= 1'b0;
      if (regWrite && regHit(regAddr, `EDB_OFS_CONFIG)) begin
        cfg_reg <= regWdata & `EDB_CONFIG_MASK;            // [RULE21]
      end
      if (regWrite && regHit(regAddr, `EDB_OFS_PAGE)) begin
        page_reg <= regWdata & `EDB_PAGE_MASK;             // [RULE14]
      end
      if (regWrite && idleNow && regHit(regAddr, `EDB_OFS_COMMAND)) begin
        cmd_reg    <= regWdata;
        upload_reg <= 1'b1;                                // [RULE1]
      end
      if (regWrite && idleNow && regHit(regAddr, `EDB_OFS_ADDR_DATA)) begin
        ad_reg <= regWdata;                                // [RULE15]
      end
      // Upload configuration at start
      if ((state_reg == ST_IDLE) && upload_reg) begin
        cfgAct_reg <= cfg_reg;
        block_reg  <= isBlock;                             // [RULE11]
      end
      // Remaining length and target address track the transfer
      if (inStrobe && strobeDone) begin
        cmd_reg[`EDB_CMD_LEN_HI:`EDB_CMD_LEN_LO] <=
          lenField - {13'h0000, unitSize};
        cmd_reg[`EDB_CMD_ADDR_HI:0] <= tgtAddr + {14'h0000, unitSize};
      end
      // DMA address advances after each Dword moved
      if (((state_reg == ST_FETCH) || (state_reg == ST_STORE)) && dmaAck) begin
        ad_reg <= ad_reg + 32'h0000_0004;                  // [RULE15]
      end
      // Immediate read lands in the address/data word
      if ((state_reg == ST_GAP) && (gap_reg == 3'h1) && !block_reg &&
          dirRead && (lenField == 15'h0000)) begin
        ad_reg <= buf_reg;
      end
    end
  end

  // Data buffer, lane pointer and strobe timing
  always @(posedge ref_clk) begin
    if (!resetn) begin
      buf_reg      <= 32'h0000_0000;
      lane_reg     <= 2'h0;
      wrap_reg     <= 1'b0;
      needAddr_reg <= 1'b0;
      cnt_reg      <= 4'h0;
      gap_reg      <= 3'h0;
      dmaWdata_reg <= 32'h0000_0000;
    end else begin
      if ((state_reg == ST_IDLE) && upload_reg) begin
        buf_reg      <= isImm ? ad_reg : 32'h0000_0000;
        lane_reg     <= isImm ? 2'h0 : tgtAddr[1:0];
        wrap_reg     <= 1'b0;
        needAddr_reg <= 1'b1;
      end
      if ((state_reg == ST_FETCH) && dmaAck) begin
        buf_reg  <= swapWord(dmaRdata, swapMode);          // [RULE6]
        wrap_reg <= 1'b0;
      end
      if ((state_reg == ST_STORE) && dmaAck) begin
        buf_reg  <= 32'h0000_0000;
        wrap_reg <= 1'b0;
      end
      if (state_next == ST_STORE) begin
        dmaWdata_reg <= swapWord(buf_reg, swapMode);
      end
      if (state_next == ST_STROBE) begin
        needAddr_reg <= 1'b0;
      end
      // Strobe cycle counter saturates while waiting on a handshake
      if (inStrobe && !strobeDone) begin
        cnt_reg <= (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1; // [RULE5]
      end else begin
        cnt_reg <= 4'h0;
      end
      // End of data phase: capture read bytes, move lane
      if (inStrobe && strobeDone) begin
        if (dirRead) begin
          buf_reg[{lane_reg, 3'b000} +: 8] <= adSync[7:0];
          if (unitWide) begin
            buf_reg[{hiLane, 3'b000} +: 8] <= adSync[15:8];
          end
        end
        lane_reg <= laneNext[1:0];
        wrap_reg <= laneNext[2];
        gap_reg  <= gapLen;
      end else if ((state_reg == ST_GAP) && (gap_reg != 3'h0)) begin
        gap_reg <= gap_reg - 3'h1;
      end
    end
  end

  // Pin drive: address in address phase, write data in strobe
  always @(posedge ref_clk) begin
    if (!resetn) begin
      adOut_reg <= 16'h0000;
      adOe_reg  <= 1'b0;
    end else begin
      adOut_reg <= (state_next == ST_STROBE) ? wrData : tgtAddr; // [RULE13]
      adOe_reg  <= (state_next == ST_ADDR1) || (state_next == ST_ADDR2) ||
                   ((state_next == ST_STROBE) && !dirRead); // [RULE12]
    end
  end

  // Sticky flags, a set in the clear cycle wins
  always @(posedge ref_clk) begin
    if (!resetn) begin
      tmoFlag_reg <= 1'b0;
      fmtFlag_reg <= 1'b0;
    end else begin
      tmoFlag_reg <= tmoEvent || (tmoFlag_reg && !timerOverflowClr); // [RULE17]
      fmtFlag_reg <= ((state_reg == ST_IDLE) && upload_reg && crossDw) ||
                     (fmtFlag_reg && !formatErrorClr);     // [RULE18]
    end
  end

  // Register read data, unmapped reads return zero
  always @(posedge ref_clk) begin
    if (!resetn) begin
      rdData_reg <= 32'h0000_0000;
    end else if (regRead) begin
      if (regHit(regAddr, `EDB_OFS_CONFIG)) begin
        rdData_reg <= cfg_reg;                             // [RULE21]
      end else if (regHit(regAddr, `EDB_OFS_COMMAND)) begin
        rdData_reg <= cmd_reg;
      end else if (regHit(regAddr, `EDB_OFS_PAGE)) begin
        rdData_reg <= page_reg;
      end else if (regHit(regAddr, `EDB_OFS_ADDR_DATA)) begin
        rdData_reg <= ad_reg;
      end else begin
        rdData_reg <= 32'h0000_0000;
      end
    end
  end

  // Sequencer state
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign regRdata          = rdData_reg;
  assign timerOverflowFlag = tmoFlag_reg;
  assign formatErrorFlag   = fmtFlag_reg;
  assign transferActive    = (state_reg != ST_IDLE);
  assign dmaReq            = (state_reg == ST_FETCH) ||
                             (state_reg == ST_STORE);
  assign dmaRead           = (state_reg == ST_FETCH);
  assign dmaAddr           = {ad_reg[31:2], 2'b00};        // [RULE16]
  assign dmaWdata          = dmaWdata_reg;
  assign dmaPagingEnable   = page_reg[`EDB_PAGE_EN];       // [RULE14]
  assign dmaPageBase       = page_reg[`EDB_PAGE_BASE_HI:`EDB_PAGE_BASE_LO];
  assign adOut             = adOut_reg;
  assign adOe              = adOe_reg;
  assign aleOut            = (state_reg == ST_ADDR1);
  // Separate strobes with ready, or one data strobe with acknowledge
  assign wrStrobeN         = !(inStrobe && readyMode && !dirRead); // [RULE9]
  assign rdStrobeN         = !(inStrobe && readyMode && dirRead);
  assign dataStrobeN       = !(inStrobe && !readyMode);
  assign readNotWrite      = transferActive && dirRead;
  assign wideCycle         = inStrobe && unitWide;

endmodule

// >>> verification/edb_checker.sv
// Checker for the external data bus command block, bound to its ports.
// Assumes the byte offsets of the shared defines header.
`timescale 1ns/100ps
`include "edb_defines.vh"
module edb_checker (
  input wire        ref_clk,
  input wire        resetn,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regAddr,
  input wire [31:0] regWdata,
  input wire [31:0] regRdata,
  input wire        formatErrorFlag,
  input wire        transferActive,
  input wire        dmaReq,
  input wire [31:0] dmaAddr,
  input wire        dmaPagingEnable,
  input wire [19:0] dmaPageBase,
  input wire [15:0] adOut,
  input wire        adOe,
  input wire        aleOut,
  input wire        wrStrobeN,
  input wire        rdStrobeN,
  input wire        dataStrobeN,
  input wire        readNotWrite
);
  // Command word writes and mapped offsets
  wire cmdWr  = regWrite && regAddr == `EDB_OFS_COMMAND;
  wire mapped = regAddr == `EDB_OFS_CONFIG || regAddr == `EDB_OFS_COMMAND ||
                regAddr == `EDB_OFS_PAGE || regAddr == `EDB_OFS_ADDR_DATA;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  strobe_excl_a: assert property (!(!wrStrobeN && !rdStrobeN))
    else $error("read and write strobes low together");
  rd_dir_a: assert property (!rdStrobeN |-> readNotWrite)
    else $error("read strobe without read direction");
  wr_dir_a: assert property (!wrStrobeN |-> !readNotWrite && adOe)
    else $error("write strobe without driven data");
  ale_addr_a: assert property ($rose(aleOut) |-> adOe ##1
    (!aleOut && $stable(adOut))) else $error("address phase malformed");
  fmt_err_a: assert property (cmdWr && !transferActive &&
    !$past(cmdWr) && regWdata[31:17] == 15'h0004 && regWdata[1:0] != 2'b00
    |-> ##2 formatErrorFlag && !transferActive)
    else $error("crossing immediate not refused");
  start_xfer_a: assert property (cmdWr && !transferActive &&
    !$past(cmdWr) && regWdata[31:17] == 15'h0001 |-> ##2 transferActive)
    else $error("command write did not start transfer");
  dma_hold_a: assert property (dmaReq && $past(dmaReq) |->
    $stable(dmaAddr) && dmaAddr[1:0] == 2'b00)
    else $error("host address moved during request");
  page_map_a: assert property (regWrite && regAddr == `EDB_OFS_PAGE
    |=> dmaPagingEnable == $past(regWdata[11]) &&
    dmaPageBase == $past(regWdata[31:12])) else $error("paging word lost");
  unmapped_a: assert property (regRead && !mapped
    |=> regRdata == 32'h0) else $error("unmapped read not zero");
  idle_quiet_a: assert property (!transferActive |->
    wrStrobeN && rdStrobeN && dataStrobeN && !dmaReq)
    else $error("bus activity while idle");
endmodule

bind edb_cmd_regs edb_checker u_chk (.ref_clk, .resetn, .regWrite, .regRead,
  .regAddr, .regWdata, .regRdata, .formatErrorFlag, .transferActive, .dmaReq,
  .dmaAddr, .dmaPagingEnable, .dmaPageBase, .adOut, .adOe, .aleOut,
  .wrStrobeN, .rdStrobeN, .dataStrobeN, .readNotWrite);

// >>> verification/edb_target_model.sv
// Behavioural 8/16-bit target peripheral on the external data bus.
// Assumes the bench picks a stalled acknowledge and the read word.
`timescale 1ns/100ps
module edb_target_model (
  input  wire        ref_clk,
  input  wire [15:0] adOut,
  input  wire        rdStrobeN,
  input  wire        wrStrobeN,
  input  wire        dataStrobeN,
  input  wire        readNotWrite,
  input  wire        stall,
  input  wire [15:0] readWord,
  output reg  [15:0] adIn,
  output reg         readyIn,
  output reg         dtackN,
  output reg  [15:0] lastWrite
);
  initial begin
    adIn = 16'h0000;
    readyIn = 1'b1;
    dtackN = 1'b1;
  end
  // Answer strobes; released bus toggles so stale data never matches
  always @(posedge ref_clk) begin
    readyIn <= 1'b1;
    dtackN <= !(!dataStrobeN && !stall);
    if (!rdStrobeN || (!dataStrobeN && readNotWrite))
      adIn <= readWord;
    else
      adIn <= ~adIn;
    if (!wrStrobeN || (!dataStrobeN && !readNotWrite))
      lastWrite <= adOut;
  end
endmodule

// >>> verification/test_ext_data_bus_cmd_regs.sv
// Self-checking bench for the external data bus command block.
// Assumes the target model beside it and a prompt DMA responder here.
`timescale 1ns/100ps
module test_ext_data_bus_cmd_regs;
  reg         ref_clk, resetn, regWrite, regRead, timerOverflowClr;
  reg         formatErrorClr, dmaAck, gpPinThree, stall, dmaSeen, dmaRd1;
  reg  [7:0]  regAddr;
  reg  [31:0] regWdata, dmaRdata, dmaAddr1, rv;
  reg  [15:0] readWord;
  wire [31:0] regRdata, dmaAddr, dmaWdata;
  wire [19:0] dmaPageBase;
  wire [15:0] adIn, adOut, lastWrite;
  wire        timerOverflowFlag, formatErrorFlag, transferActive, dmaReq;
  wire        dmaRead, dmaPagingEnable, adOe, aleOut, wrStrobeN, rdStrobeN;
  wire        dataStrobeN, readNotWrite, wideCycle, readyIn, dtackN;
  wire        stbAny = !wrStrobeN || !rdStrobeN || !dataStrobeN;
  int         fails, tests_run, cyc, w, ns, na;
  reg  [15:0] aa;

  edb_cmd_regs uut (.ref_clk, .resetn, .regWrite, .regRead, .regAddr,
    .regWdata, .regRdata, .timerOverflowClr, .formatErrorClr,
    .timerOverflowFlag, .formatErrorFlag, .transferActive, .dmaReq,
    .dmaRead, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata, .dmaPagingEnable,
    .dmaPageBase, .adIn, .adOut, .adOe, .aleOut, .wrStrobeN, .rdStrobeN,
    .dataStrobeN, .readNotWrite, .wideCycle, .readyIn, .dtackN,
    .gpPinThree);

  edb_target_model target (.ref_clk, .adOut, .rdStrobeN, .wrStrobeN,
    .dataStrobeN, .readNotWrite, .stall, .readWord, .adIn, .readyIn,
    .dtackN, .lastWrite);

  // Clock starting low at time zero, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Prompt DMA engine, records the first request of a transfer
  always @(posedge ref_clk) begin
    dmaAck <= dmaReq && !dmaAck;
    if (transferActive !== 1'b1) begin
      dmaSeen <= 1'b0;
    end else if (dmaReq && !dmaSeen) begin
      dmaSeen <= 1'b1;
      dmaRd1 <= dmaRead;
      dmaAddr1 <= dmaAddr;
    end
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude;
    end
  end

  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp, input string nm);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rv = regRdata;
    if (nm != "") chk(nm, exp, rv);
  endtask
  // Starts a command and measures strobes and address phases
  task automatic run(input [31:0] cmd);
    int n;
    bit prev;
    w = 0; ns = 0; na = 0; prev = 0; n = 0;
    wr(8'h80, cmd);
    while ((transferActive === 1'b1 || n < 3) && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
      if (aleOut === 1'b1) begin
        na++;
        aa = adOut;
      end
      if (stbAny) w++;
      if (stbAny && !prev) ns++;
      prev = stbAny;
    end
    chk("xfer end", 32'h0, {31'h0, transferActive});
  endtask
  task automatic pulse_clr;
    @(posedge ref_clk);
    timerOverflowClr <= 1'b1;
    formatErrorClr <= 1'b1;
    @(posedge ref_clk);
    timerOverflowClr <= 1'b0;
    formatErrorClr <= 1'b0;
  endtask

  // Reset values, masks and unmapped offset
  task t_regs;
    rd(8'h7C, 32'h0, "config rst");
    rd(8'h84, 32'h0, "page rst");
    rd(8'h90, 32'h0, "unmapped");
    wr(8'h7C, 32'hFFFF_FFFF);
    rd(8'h7C, 32'hD3FF_0000, "config mask");
    wr(8'h84, 32'hFFFF_FFFF);
    rd(8'h84, 32'hFFFF_F800, "page mask");
    chk("page base", 32'h000F_FFFF, {12'h000, dmaPageBase});
    chk("paging en", 32'h1, {31'h0, dmaPagingEnable});
    wr(8'h84, 32'h0);
    wr(8'h88, 32'h1234_5678);
    rd(8'h88, 32'h1234_5678, "addr data");
  endtask
  // Immediate 16-bit write, ready handshake, timer 2 gives strobe of 3
  task t_imm_wr;
    wr(8'h7C, 32'h108A_0000);
    wr(8'h88, 32'h0000_C3A5);
    run(32'h0004_1234);
    chk("ale addr", 32'h1234, {16'h0, aa});
    chk("wr width", 3, w);
    chk("wr word", 32'hC3A5, {16'h0, lastWrite});
  endtask
  // Immediate read, timer 6 gives strobe of 7
  task t_imm_rd;
    readWord <= 16'h005A;
    wr(8'h7C, 32'h1182_0000);
    run(32'h0003_0010);
    chk("rd width", 7, w);
    rd(8'h88, 32'h0, "");
    chk("rd byte", 32'h5A, {24'h0, rv[7:0]});
  endtask
  // Immediate crossing a Dword is refused
  task t_fmt;
    wr(8'h88, 32'h0);
    wr(8'h80, 32'h0008_0001);
    repeat (2) @(posedge ref_clk);
    #1 chk("fmt flag", 32'h1, {31'h0, formatErrorFlag});
    chk("no start", 32'h0, {31'h0, transferActive});
    pulse_clr;
    #1 chk("fmt clr", 32'h0, {31'h0, formatErrorFlag});
  endtask
  // Acknowledge handshake without timer, then a stalled target
  task t_ack;
    stall <= 1'b0;
    wr(8'h7C, 32'h0001_0000);
    run(32'h0002_0000);
    chk("ack strobes", 1, ns);
    chk("no ovf", 32'h0, {31'h0, timerOverflowFlag});
    stall <= 1'b1;
    wr(8'h7C, 32'h0080_0000);
    run(32'h0002_0000);
    chk("ovf flag", 32'h1, {31'h0, timerOverflowFlag});
    stall <= 1'b0;
    pulse_clr;
  endtask
  // Incrementing block write of 8 bytes, two-byte swap, 8-bit target
  task t_block;
    wr(8'h7C, 32'h0016_0000);
    wr(8'h88, 32'h0000_1000);
    run(32'h0010_0100);
    chk("blk strobes", 8, ns);
    chk("blk addr ph", 8, na);
    chk("blk swap", 32'h33, {24'h0, lastWrite[7:0]});
    chk("dma fetch", 32'h1, {31'h0, dmaRd1});
    chk("dma addr", 32'h0000_1000, dmaAddr1);
  endtask

  task conclude;
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    {resetn, regWrite, regRead, timerOverflowClr, formatErrorClr} = 5'b0;
    stall = 1'b0;
    gpPinThree = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    dmaRdata = 32'h4433_2211;
    readWord = 16'h0000;
    fails = 0; tests_run = 0; cyc = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs;
    t_imm_wr;
    t_imm_rd;
    t_fmt;
    t_ack;
    t_block;
    conclude;
  end
endmodule
